// File: verilog/clock_ctrl_map.svh
// register offsets, field positions, reset values and source codes of the clock controller
`ifndef CLOCK_CTRL_MAP_SVH
`define CLOCK_CTRL_MAP_SVH
`define OFS_PWRCTL 8'h00
`define OFS_CLOCK_SELECT_REGISTER_ZERO 8'h04
`define OFS_CLKSEL1 8'h08
`define OFS_DIVCTL 8'h0C
`define OFS_TICKCTL 8'h10
`define OFS_STATUS 8'h14
`define PWR_PD_EN_BIT 7
`define PWR_WAIT_CORE_BIT 8
`define SEL0_SYS_LSB 0
`define SEL0_TICK_LSB 3
`define SEL1_DIV_LSB 0
`define SEL1_PLLREF_BIT 2
`define DIV_N_LSB 0
`define DIV_EN_BIT 4
`define DIV_BYPASS_BIT 5
`define TICK_CPU_BIT 2
`define PWRCTL_RST 32'h0000_0000
`define CLOCK_SELECT_REGISTER_ZERO_RST 32'h0000_0000
`define CLKSEL1_RST 32'h0000_0000
`define DIVCTL_RST 32'h0000_0000
`define TICKCTL_RST 32'h0000_0000
`define SRC_XTAL 3'h0
`define SRC_PLL 3'h1
`define SRC_SLOWRC 3'h2
`define SRC_FASTRC 3'h3
`endif

// File: verilog/clock_ctrl_pkg.sv
// types shared by the clock controller
package clock_ctrl_pkg;
  typedef enum logic [0:0] {
    PM_RUN = 1'b0,
    PM_DOWN = 1'b1
  } power_state_e;
  typedef logic [31:0] word_t;
endpackage

// File: verilog/chip_clock_and_divider_control.sv
// clock source selection, power-down control and clock-out divider with ahb-lite registers
`timescale 1ns/1ps
`include "clock_ctrl_map.svh"
module chip_clock_and_divider_control
  import clock_ctrl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic XTAL_CLK,
  input wire logic PLL_CLK,
  input wire logic FASTRC_CLK,
  input wire logic SLOWRC_CLK,
  input wire logic CORE_WFI,
  input wire logic WAKE_IRQ,
  output logic XTAL_EN,
  output logic FASTRC_EN,
  output logic PLL_EN,
  output logic SLOWRC_EN,
  output logic PLL_REF_FASTRC,
  output logic POWER_DOWN,
  output logic SYS_CLK,
  output logic TICK_CLK,
  output logic CLOCK_OUT
);

  // source index: 0 crystal, 1 pll, 2 slow rc, 3 fast rc, 4 wake
  logic [4:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  word_t pwr_r, pwr_nxt, sel0_r, sel0_nxt, sel1_r, sel1_nxt, div_r, div_nxt, tick_r, tick_nxt;
  word_t hrdata_r, hrdata_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  power_state_e pm_r, pm_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic div_prev_r, div_prev_nxt;
  logic sys_r, sys_nxt, tick_clk_r, tick_clk_nxt, cko_r, cko_nxt;
  logic xen_r, xen_nxt, fen_r, fen_nxt, pen_r, pen_nxt, pref_r, pref_nxt;
  logic div_src, div_rise, div_run, sel_stage;

  // picks one of the four generator levels; unused codes fall back to fast rc
  function automatic logic pick_src(input logic [2:0] code, input logic [4:0] lv);
    case (code)
      `SRC_XTAL: pick_src = lv[0];
      `SRC_PLL: pick_src = lv[1];
      `SRC_SLOWRC: pick_src = lv[2];
      `SRC_FASTRC: pick_src = lv[3];
      default: pick_src = lv[3];
    endcase
  endfunction

  // a level only changes once two late stages agree, filtering metastable samples
  always_comb
  begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < 5; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s1_r <= 5'h0_0;
      s2_r <= 5'h0_0;
      s3_r <= 5'h0_0;
      lvl_r <= 5'h0_0;
    end
    else
    begin
      s1_r <= {WAKE_IRQ, FASTRC_CLK, SLOWRC_CLK, PLL_CLK, XTAL_CLK};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // bus slave: zero wait states, read data built from next register values so a
  // read straight after a write returns the new value
  always_comb
  begin
    pwr_nxt = pwr_r;
    sel0_nxt = sel0_r;
    sel1_nxt = sel1_r;
    div_nxt = div_r;
    tick_nxt = tick_r;
    hrdata_nxt = hrdata_r;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    if (wr_pend_r)
    begin
      case (wr_addr_r)
        `OFS_PWRCTL: pwr_nxt = {23'h00_0000, HWDATA[8:0]};
        `OFS_CLOCK_SELECT_REGISTER_ZERO: sel0_nxt = {26'h000_0000, HWDATA[5:0]};
        `OFS_CLKSEL1: sel1_nxt = {29'h000_0000, HWDATA[2:0]};
        `OFS_DIVCTL: div_nxt = {26'h000_0000, HWDATA[5:0]};
        `OFS_TICKCTL: tick_nxt = {29'h000_0000, HWDATA[2:0]};
        default: ;
      endcase
    end
    if (pm_r == PM_RUN && CORE_WFI && pwr_r[`PWR_PD_EN_BIT] && pwr_r[`PWR_WAIT_CORE_BIT])
    begin
      pwr_nxt[`PWR_PD_EN_BIT] = 1'b0; // wake leaves enable cleared so the next wfi does not re-enter
    end
    if (HSEL && HREADY && HTRANS[1])
    begin
      wr_pend_nxt = HWRITE;
      wr_addr_nxt = {HADDR[7:2], 2'b00};
      if (!HWRITE)
      begin
        case ({HADDR[7:2], 2'b00})
          `OFS_PWRCTL: hrdata_nxt = pwr_nxt;
          `OFS_CLOCK_SELECT_REGISTER_ZERO: hrdata_nxt = sel0_nxt;
          `OFS_CLKSEL1: hrdata_nxt = sel1_nxt;
          `OFS_DIVCTL: hrdata_nxt = div_nxt;
          `OFS_TICKCTL: hrdata_nxt = tick_nxt;
          `OFS_STATUS: hrdata_nxt = {26'h000_0000, div_run, pm_r == PM_DOWN, lvl_r[3:0]};
          default: hrdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pwr_r <= `PWRCTL_RST;
      sel0_r <= `CLOCK_SELECT_REGISTER_ZERO_RST;
      sel1_r <= `CLKSEL1_RST;
      div_r <= `DIVCTL_RST;
      tick_r <= `TICKCTL_RST;
      hrdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      sel0_r <= sel0_nxt;
      sel1_r <= sel1_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      hrdata_r <= hrdata_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
    end
  end

  // power-down sequencer
  always_comb
  begin
    pm_nxt = pm_r;
    case (pm_r)
      PM_RUN:
      begin
        if (CORE_WFI && pwr_r[`PWR_PD_EN_BIT] && pwr_r[`PWR_WAIT_CORE_BIT])
        begin
          pm_nxt = PM_DOWN;
        end
      end
      PM_DOWN:
      begin
        if (lvl_r[4])
        begin
          pm_nxt = PM_RUN;
        end
      end
      default: pm_nxt = PM_RUN;
    endcase
    xen_nxt = (pm_nxt == PM_RUN);
    fen_nxt = (pm_nxt == PM_RUN);
    pen_nxt = (pm_nxt == PM_RUN);
    pref_nxt = sel1_r[`SEL1_PLLREF_BIT];
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pm_r <= PM_RUN;
      xen_r <= 1'b1;
      fen_r <= 1'b1;
      pen_r <= 1'b1;
      pref_r <= 1'b0;
    end
    else
    begin
      pm_r <= pm_nxt;
      xen_r <= xen_nxt;
      fen_r <= fen_nxt;
      pen_r <= pen_nxt;
      pref_r <= pref_nxt;
    end
  end

  // clock muxes; in power-down every source but the slow rc reads as stopped
  logic [4:0] live;
  always_comb
  begin
    live = lvl_r;
    if (pm_r == PM_DOWN)
    begin
      live[0] = 1'b0;
      live[1] = 1'b0;
      live[3] = 1'b0;
    end
    div_src = pick_src(sel1_r[`SEL1_DIV_LSB +: 3], live);
    div_rise = div_src && !div_prev_r;
    sel_stage = cnt_r[div_r[`DIV_N_LSB +: 4]];
    div_run = div_r[`DIV_EN_BIT] || sel_stage;
    cnt_nxt = cnt_r;
    if (div_run && div_rise)
    begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    div_prev_nxt = div_src;
    // gate on the next state so the system clock is already low in the first power-down cycle
    sys_nxt = (pm_nxt == PM_RUN) && pick_src(sel0_r[`SEL0_SYS_LSB +: 3], live);
    if (tick_r[`TICK_CPU_BIT])
    begin
      tick_clk_nxt = sys_nxt;
    end
    else
    begin
      tick_clk_nxt = pick_src(sel0_r[`SEL0_TICK_LSB +: 3], live);
    end
    if (div_r[`DIV_BYPASS_BIT])
    begin
      cko_nxt = div_r[`DIV_EN_BIT] && div_src;
    end
    else
    begin
      cko_nxt = cnt_nxt[div_r[`DIV_N_LSB +: 4]];
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cnt_r <= 16'h0000;
      div_prev_r <= 1'b0;
      sys_r <= 1'b0;
      tick_clk_r <= 1'b0;
      cko_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      div_prev_r <= div_prev_nxt;
      sys_r <= sys_nxt;
      tick_clk_r <= tick_clk_nxt;
      cko_r <= cko_nxt;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign XTAL_EN = xen_r;
  assign FASTRC_EN = fen_r;
  assign PLL_EN = pen_r;
  assign SLOWRC_EN = 1'b1;
  assign PLL_REF_FASTRC = pref_r;
  assign POWER_DOWN = (pm_r == PM_DOWN);
  assign SYS_CLK = sys_r;
  assign TICK_CLK = tick_clk_r;
  assign CLOCK_OUT = cko_r;

endmodule

// File: tb/clock_ctrl_chk.sv
// port assertions for the clock controller
`timescale 1ns/1ps
module clock_ctrl_chk (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic HWRITE,
  input wire logic CORE_WFI,
  input wire logic WAKE_IRQ,
  input wire logic XTAL_EN,
  input wire logic FASTRC_EN,
  input wire logic PLL_EN,
  input wire logic SLOWRC_EN,
  input wire logic PLL_REF_FASTRC,
  input wire logic POWER_DOWN,
  input wire logic SYS_CLK
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  a_slow_alive: assert property (SLOWRC_EN)
    else $error("slow rc stopped");
  a_osc_stop: assert property (XTAL_EN == !POWER_DOWN && FASTRC_EN == !POWER_DOWN)
    else $error("fast oscillators wrong for power state");
  a_pll_stop: assert property (PLL_EN == !POWER_DOWN)
    else $error("pll wrong for power state");
  a_pd_cause: assert property ($rose(POWER_DOWN) |-> $past(CORE_WFI))
    else $error("sleep without core request");
  a_pd_hold: assert property ((POWER_DOWN && !WAKE_IRQ) [*4] |=> POWER_DOWN)
    else $error("left sleep without wake");
  a_pd_wake: assert property (POWER_DOWN && WAKE_IRQ |-> ##[1:6] !POWER_DOWN)
    else $error("wake ignored");
  a_sys_stop: assert property (POWER_DOWN |-> !SYS_CLK)
    else $error("system clock runs in sleep");
  // pll reference may only move after a bus write
  a_pll_ref: assert property ($changed(PLL_REF_FASTRC) |-> $past(HSEL && HWRITE, 2) || $past(HSEL && HWRITE, 3))
    else $error("pll reference moved without write");
endmodule
bind chip_clock_and_divider_control clock_ctrl_chk u_clock_ctrl_chk (.*);

// File: tb/osc_model.sv
// oscillator model: four sources, each held low while its enable is off
`timescale 1ns/1ps
module osc_model (
  input wire logic XTAL_EN,
  input wire logic PLL_EN,
  input wire logic FASTRC_EN,
  input wire logic SLOWRC_EN,
  output logic XTAL_CLK,
  output logic PLL_CLK,
  output logic FASTRC_CLK,
  output logic SLOWRC_CLK
);
  // whole-cycle periods phased off the sampling edge, so sampled periods are exact
  logic [3:0] osc = '0;
  initial #5 forever #50 osc[0] = ~osc[0];
  initial #5 forever #75 osc[1] = ~osc[1];
  initial #5 forever #100 osc[2] = ~osc[2];
  initial #5 forever #125 osc[3] = ~osc[3];
  assign XTAL_CLK = osc[0] & XTAL_EN;
  assign PLL_CLK = osc[1] & PLL_EN;
  assign FASTRC_CLK = osc[2] & FASTRC_EN;
  assign SLOWRC_CLK = osc[3] & SLOWRC_EN;
endmodule

// File: tb/chip_clock_and_divider_control_bench.sv
// self-checking bench for the clock controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module chip_clock_and_divider_control_bench import clock_ctrl_pkg::*;;
  logic MCLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, CORE_WFI = 0, WAKE_IRQ = 0;
  logic [7:0] HADDR = '0;
  logic [1:0] HTRANS = '0;
  logic [1:0] msel = '0;
  word_t HWDATA = '0, HRDATA, rdat;
  word_t pdv[3] = '{32'h0000_0080, 32'h0000_0100, 32'h0000_0180};
  logic HREADYOUT, HRESP, XTAL_EN, FASTRC_EN, PLL_EN, SLOWRC_EN, PLL_REF_FASTRC, POWER_DOWN;
  logic SYS_CLK, TICK_CLK, CLOCK_OUT, XTAL_CLK, PLL_CLK, FASTRC_CLK, SLOWRC_CLK;
  int num_errors = 0, checked = 0, hi = 0;
  int tab[4] = '{4, 6, 10, 8};
  realtime t0;
  wire mon = msel == 0 ? SYS_CLK : msel == 1 ? TICK_CLK : CLOCK_OUT;
  chip_clock_and_divider_control u_chip_clock_and_divider_control (.*, .HSIZE(3'h2), .HREADY(HREADYOUT));
  osc_model u_osc_model (.*);
  initial forever #12.5 MCLK = ~MCLK;
  task automatic bus(input logic w, input logic [7:0] a, input word_t d);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    rdat = HRDATA;
  endtask
  task automatic rc(input logic [7:0] a, input word_t e);
    bus(1'b0, a, '0);
    `CHK("register", e, rdat)
  endtask
  // skip the sync settling, then time one full period of the chosen output
  task automatic per(input logic [1:0] s, input int e);
    msel = s;
    repeat (8) @(posedge MCLK);
    @(posedge mon);
    t0 = $realtime;
    @(posedge mon);
    `CHK("period", e, int'(($realtime - t0) / 25.0))
  endtask
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #1ms;
    num_errors++;
    finish_test();
  end
  initial
  begin
    repeat (16) @(posedge MCLK);
    RESET_N <= 1'b1;
    for (int i = 0; i < 5; i++)
      rc(8'(i * 4), '0);
    bus(1'b1, 8'h18, 32'hffff_ffff);
    rc(8'h18, '0);
    `CHK("response", 1'b0, HRESP)
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h04, 32'(i));
      per(2'h0, tab[i > 3 ? 3 : i]);
    end
    bus(1'b1, 8'h10, '0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h04, 32'(i << 3));
      per(2'h1, tab[i]);
    end
    bus(1'b1, 8'h10, 32'h0000_0004);
    per(2'h1, 4);
    bus(1'b1, 8'h08, 32'h0000_0004);
    repeat (2) @(posedge MCLK);
    `CHK("pll ref", 1'b1, PLL_REF_FASTRC)
    bus(1'b1, 8'h08, '0);
    repeat (2) @(posedge MCLK);
    `CHK("pll ref", 1'b0, PLL_REF_FASTRC)
    for (int n = 0; n < 4; n++)
    begin
      bus(1'b1, 8'h0c, 32'(16 + n));
      per(2'h2, 4 << (n + 1));
    end
    bus(1'b1, 8'h0c, 32'h0000_0030);
    per(2'h2, 4);
    bus(1'b1, 8'h0c, 32'h0000_0013);
    // let the bypass-to-chain switch settle so the timed rise is a genuine one
    repeat (2) @(posedge MCLK);
    @(negedge CLOCK_OUT);
    @(posedge CLOCK_OUT);
    t0 = $realtime;
    bus(1'b1, 8'h0c, 32'h0000_0003);
    @(negedge CLOCK_OUT);
    `CHK("high time", 32, int'(($realtime - t0) / 25.0))
    repeat (200) @(posedge MCLK) if (CLOCK_OUT !== 1'b0) hi++;
    `CHK("halted", 0, hi)
    foreach (pdv[k])
    begin
      bus(1'b1, 8'h00, pdv[k]);
      @(posedge MCLK) CORE_WFI <= 1'b1;
      @(posedge MCLK) CORE_WFI <= 1'b0;
      repeat (2) @(posedge MCLK);
      `CHK("sleep", k == 2, POWER_DOWN)
    end
    `CHK("xtal", 1'b0, XTAL_EN)
    `CHK("pll", 1'b0, PLL_EN)
    `CHK("slow rc", 1'b1, SLOWRC_EN)
    rc(8'h00, 32'h0000_0100);
    bus(1'b0, 8'h14, '0);
    `CHK("status", 2'h1, rdat[5:4])
    repeat (20) @(posedge MCLK);
    `CHK("asleep", 1'b1, POWER_DOWN)
    @(posedge MCLK) WAKE_IRQ <= 1'b1;
    repeat (8) @(posedge MCLK);
    `CHK("awake", 1'b0, POWER_DOWN)
    `CHK("fast rc", 1'b1, FASTRC_EN)
    finish_test();
  end
endmodule
